//--- core/extended_alu_op_regs.svh
// Register offsets, field positions and reset values of the extended ALU.
`ifndef EXTENDED_ALU_OP_REGS_SVH
`define EXTENDED_ALU_OP_REGS_SVH

// ************************************************************
// Register word indices (byte offset is four times the index)
// ************************************************************
`define REG_EXT_CTRL_IDX 2'h0
`define REG_RESULT_IDX 2'h1
`define REG_STATUS_IDX 2'h2

// ************************************************************
// Extension control register fields
// ************************************************************
`define FN_CODE_LSB 19
`define FN_CODE_MSB 26
`define ARITH_MODE_BIT 27
`define ADD_SEL_LSB 28
`define ADD_SEL_MSB 29
`define SIGN_EN_BIT 30
`define SIGN_SRC_BIT 31
`define EXT_CTRL_RST 32'h0000_0000
`define EXT_CTRL_MASK 32'hfff8_0000

// ************************************************************
// Status register fields
// ************************************************************
`define STAT_CARRY_BIT 0
`define STAT_ARITH_BIT 1
`define STAT_SIGN_BIT 2
`define RESULT_RST 32'h0000_0000

`endif

//--- core/extended_alu_op_pkg.sv
// Types shared by the extended ALU modules.
package extended_alu_op_pkg;

	// Operands and carry delivered with one instruction.
	typedef struct packed {
		logic [31:0] a;
		logic [31:0] b;
		logic [31:0] c;
		logic cin;
	} operands_s;

	// What is added to the function result.
	typedef enum logic [1:0] {
		add_none = 2'b00,
		add_one = 2'b01,
		add_cin = 2'b10
	} add_sel_e;

	// Per-bit function vectors produced by the bit logic.
	typedef struct packed {
		logic [31:0] bool_v;
		logic [31:0] prod_v;
		logic [31:0] sum_v;
	} fn_vec_s;

endpackage : extended_alu_op_pkg

//--- core/extended_alu_op_bit_fn.sv
// Bitwise minterm and subterm evaluation for the extended ALU.
`timescale 1ns/1ps
`default_nettype none

module extended_alu_op_bit_fn (
	// Operands
	input wire logic [31:0] a,
	input wire logic [31:0] b,
	input wire logic [31:0] c,
	// Function code, minterm_select_0 in bit 0
	input wire logic [7:0] code,
	// Per-bit results
	output extended_alu_op_pkg::fn_vec_s vec
);
	import extended_alu_op_pkg::*;

	// Picks the code bit for minterm index a + 2b + 4c.
	function automatic logic minterm_pick(input logic [7:0] fc,
		input logic ai, input logic bi, input logic ci);
		minterm_pick = fc[{ci, bi, ai}];
	endfunction : minterm_pick

	// Each position is evaluated on its own, so no carry crosses bits.
	for (genvar i = 0; i < 32; i++) begin : g_bit
		wire logic even_t;
		wire logic odd_t;
		// OR of the eight gated minterms is a lookup.
		assign vec.bool_v[i] = minterm_pick(code, a[i], b[i], c[i]);
		// Sum subterm sits on the A-false minterms.
		assign even_t = minterm_pick(code, 1'b0, b[i], c[i]);
		// Product subterm is the xor of both halves.
		assign odd_t = minterm_pick(code, 1'b1, b[i], c[i]);
		assign vec.sum_v[i] = even_t;
		assign vec.prod_v[i] = odd_t ^ even_t;
	end

endmodule : extended_alu_op_bit_fn

`default_nettype wire

//--- core/extended_alu_op_top.sv
// Three-input extended ALU with its control registers on Avalon-MM.
//
// Decided for this implementation: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
`include "extended_alu_op_regs.svh"

// What this block does
// - Extended ops take operands from instruction, function from control register.
// - Function code lives in control bits 19 to 26, select 0 lowest.
// - Boolean result bit is OR of code-gated minterms of A, B, C.
// - Optionally add one or carry input to the Boolean result.
// - Arithmetic mode computes A AND product subterm plus sum subterm.
// - Product and sum subterms are bitwise functions of B and C.
// - Codes for zero, minus one, B, C and their negations.
// - Codes for B AND C, B OR C and their negations.
// - Codes for B AND NOT C, B OR NOT C and negations.
// - Codes 28/3C and 82/C3 pick B or minus B by C.
// - Control bits let an input's sign alter the applied function.
module extended_alu_op_top (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// Avalon-MM slave
	input wire logic [1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Instruction issue from decode
	input wire logic op_valid,
	input wire logic extended_alu_op,
	input wire logic [7:0] base_fn,
	input wire logic base_arith,
	input wire extended_alu_op_pkg::operands_s ops,
	// Result to the register file
	output logic result_valid,
	output logic [31:0] result,
	output logic carry_out
);
	import extended_alu_op_pkg::*;

	// ************************************************************
	// Register bus slave
	// ************************************************************
	logic ack_reg;
	logic [31:0] readdata_reg;
	logic [31:0] ext_ctrl_reg;
	logic [31:0] result_reg;
	logic carry_reg;
	logic arith_reg;
	logic sign_reg;
	logic result_valid_reg;
	wire logic bus_req;
	wire logic ack_next;
	wire logic ctrl_wr;
	wire logic [31:0] be_mask;
	wire logic [31:0] ext_ctrl_next;
	wire logic [31:0] status_word;
	wire logic [31:0] rd_word;

	// Every access takes one wait state, which keeps read data a flop.
	assign bus_req = avs_read | avs_write;
	assign ack_next = bus_req & ~ack_reg;
	assign avs_waitrequest = bus_req & ~ack_reg;
	assign avs_readdata = readdata_reg;

	// Writes land only at the edge that completes the access.
	assign ctrl_wr = avs_write & ack_reg &
		(avs_address == `REG_EXT_CTRL_IDX);
	assign be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
		{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
	assign ext_ctrl_next = ((ext_ctrl_reg & ~be_mask) |
		(avs_writedata & be_mask)) & `EXT_CTRL_MASK;

	// Status bits describe the most recent result.
	assign status_word = {29'h0, sign_reg, arith_reg, carry_reg};

	// Unmapped words read as zero and ignore writes.
	assign rd_word = (avs_address == `REG_EXT_CTRL_IDX) ? ext_ctrl_reg :
		(avs_address == `REG_RESULT_IDX) ? result_reg :
		(avs_address == `REG_STATUS_IDX) ? status_word : 32'h0;

	// Handshake and read data capture.
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			ack_reg <= 1'b0;
			readdata_reg <= 32'h0;
		end else begin
			ack_reg <= ack_next;
			if (avs_read & ~ack_reg) begin
				readdata_reg <= rd_word;
			end
		end
	end

	// Extension control register.
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			ext_ctrl_reg <= `EXT_CTRL_RST;
		end else if (ctrl_wr) begin
			ext_ctrl_reg <= ext_ctrl_next;
		end
	end

	// ************************************************************
	// Function selection
	// ************************************************************
	wire logic [7:0] ctrl_code;
	wire logic ctrl_arith;
	wire logic [1:0] ctrl_add;
	wire logic sign_bit;
	wire logic sign_flip;
	wire logic [7:0] code_sel;
	wire logic [7:0] code_used;
	wire logic arith_sel;
	add_sel_e add_sel;
	add_sel_e add_used;

	// The code field comes from the control register.
	assign ctrl_code = ext_ctrl_reg[`FN_CODE_MSB:`FN_CODE_LSB];
	assign ctrl_arith = ext_ctrl_reg[`ARITH_MODE_BIT];
	assign ctrl_add = ext_ctrl_reg[`ADD_SEL_MSB:`ADD_SEL_LSB];

	// Extended ops ignore the base function field.
	assign code_sel = extended_alu_op ? ctrl_code : base_fn;
	assign arith_sel = extended_alu_op ? ctrl_arith : base_arith;

	// The illegal add code 11 adds nothing.
	always_comb begin
		add_sel = add_none;
		if (extended_alu_op) begin
			unique case (ctrl_add)
				2'b01: add_sel = add_one;
				2'b10: add_sel = add_cin;
				default: add_sel = add_none;
			endcase
		end
	end

	// A negative sign input inverts the code and adds one, so a
	// B code becomes minus B; this gives absolute values.
	assign sign_bit = ext_ctrl_reg[`SIGN_SRC_BIT] ? ops.b[31] : ops.c[31];
	assign sign_flip = extended_alu_op & ext_ctrl_reg[`SIGN_EN_BIT] &
		sign_bit;
	assign code_used = sign_flip ? ~code_sel : code_sel;
	assign add_used = sign_flip ? add_one : add_sel;

	// ************************************************************
	// Datapath
	// ************************************************************
	fn_vec_s vec;
	wire logic add_bit;
	wire logic [32:0] add_word;
	wire logic [32:0] bool_sum;
	wire logic [32:0] arith_sum;
	wire logic [32:0] final_sum;

	// Minterm and subterm vectors for all 32 positions.
	extended_alu_op_bit_fn u_bit_fn (
		.a(ops.a),
		.b(ops.b),
		.c(ops.c),
		.code(code_used),
		.vec(vec)
	);

	assign add_bit = (add_used == add_one) ? 1'b1 :
		(add_used == add_cin) ? ops.cin : 1'b0;
	assign add_word = {32'h0, add_bit};

	// Boolean result plus the optional one or carry.
	assign bool_sum = {1'b0, vec.bool_v} + add_word;
	// Ripple from bit zero across the word.
	assign arith_sum = {1'b0, ops.a & vec.prod_v} + {1'b0, vec.sum_v} +
		add_word;
	assign final_sum = arith_sel ? arith_sum : bool_sum;

	// Result captured one cycle after issue.
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			result_reg <= `RESULT_RST;
			carry_reg <= 1'b0;
			arith_reg <= 1'b0;
			sign_reg <= 1'b0;
			result_valid_reg <= 1'b0;
		end else begin
			result_valid_reg <= op_valid;
			if (op_valid) begin
				result_reg <= final_sum[31:0];
				carry_reg <= final_sum[32];
				arith_reg <= arith_sel;
				sign_reg <= sign_flip;
			end
		end
	end

	assign result = result_reg;
	assign carry_out = carry_reg;
	assign result_valid = result_valid_reg;

	// ************************************************************
	// Assertions
	// ************************************************************
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!nrst);

	// A bus request is stalled exactly one cycle.
	sequence bus_stall;
		bus_req && avs_waitrequest;
	endsequence

	sequence issue_plain;
		op_valid && !sign_flip && add_used == add_none;
	endsequence

	bus_one_wait_a: assert property (bus_stall |=> !avs_waitrequest)
		else $error("bus access not acknowledged after one wait");

	code_from_ctrl_a: assert property (
		extended_alu_op |-> code_sel == ext_ctrl_reg[26:19])
		else $error("extended code not taken from bits 19 to 26");

	base_code_used_a: assert property (
		op_valid && !extended_alu_op |-> code_used == base_fn &&
		add_used == add_none && arith_sel == base_arith)
		else $error("base op did not use the base function field");

	bool_pick_c_a: assert property (
		issue_plain ##0 (!arith_sel && code_used == 8'hf0)
		|=> result_valid && result == $past(ops.c))
		else $error("boolean code f0 did not give C");

	bool_add_one_a: assert property (
		op_valid && !arith_sel && code_used == 8'h00 &&
		add_used == add_one |=> result == 32'h1 && !carry_out)
		else $error("zero function plus one did not give one");

	arith_ab_plus_a: assert property (
		issue_plain ##0 (arith_sel && code_used == 8'h44)
		|=> result == (($past(ops.a) & $past(ops.b)) + $past(ops.b)))
		else $error("arithmetic A and B plus B is wrong");

	arith_dec_a: assert property (
		issue_plain ##0 (arith_sel && code_used == 8'h55)
		|=> result == $past(ops.a) - 32'h1 &&
		carry_out == ($past(ops.a) != 32'h0))
		else $error("A minus one or its carry is wrong");

	arith_or_a: assert property (
		issue_plain ##0 (arith_sel && code_used == 8'hfc)
		|=> result == ($past(ops.b) | $past(ops.c)))
		else $error("B or C sum subterm is wrong");

	arith_andnot_a: assert property (
		issue_plain ##0 (arith_sel && code_used == 8'h0c)
		|=> result == ($past(ops.b) & ~$past(ops.c)))
		else $error("B and not C sum subterm is wrong");

	cond_negate_a: assert property (
		op_valid && arith_sel && code_used == 8'h3c &&
		add_used == add_one && ops.c == 32'hffff_ffff
		|=> result == 32'h0 - $past(ops.b))
		else $error("code 3c plus one with C ones is not minus B");

	sign_invert_a: assert property (
		op_valid && sign_flip |=> sign_reg ##0
		result == ($past(arith_sum[31:0] & {32{arith_sel}}) |
		$past(bool_sum[31:0] & {32{!arith_sel}})) &&
		$past(code_used) == ~$past(code_sel))
		else $error("sign control did not invert the code");

	ctrl_write_a: assert property (
		ctrl_wr && avs_byteenable == 4'hf
		|=> ext_ctrl_reg == ($past(avs_writedata) & 32'hfff8_0000))
		else $error("control write did not land");

endmodule : extended_alu_op_top

`default_nettype wire

//--- verif/extended_alu_op_decode_model.sv
// Instruction decode and register file model feeding the extended ALU.
`timescale 1ns/1ps
`default_nettype none

module extended_alu_op_decode_model (
	// Clock
	input wire logic ref_clk,
	// Issue side
	output logic op_valid,
	output logic extended_alu_op,
	output logic [7:0] base_fn,
	output logic base_arith,
	output extended_alu_op_pkg::operands_s ops,
	// Result side
	input wire logic result_valid,
	input wire logic [31:0] result,
	input wire logic carry_out
);
	import extended_alu_op_pkg::*;

	// Lines start idle so nothing is issued before reset ends.
	initial begin
		op_valid = 1'b0;
		extended_alu_op = 1'b0;
		base_fn = 8'h00;
		base_arith = 1'b0;
		ops = '0;
	end

	// Issues one instruction and waits for its result pulse.
	// Operands flip after issue so a stale value is never mistaken for live.
	task automatic issue(input logic ext, input logic [7:0] fn,
		input logic ar, input operands_s o,
		output logic [32:0] got, output logic ok);
		ok = 1'b0;
		got = '0;
		@(posedge ref_clk);
		op_valid <= 1'b1;
		extended_alu_op <= ext;
		base_fn <= fn;
		base_arith <= ar;
		ops <= o;
		@(posedge ref_clk);
		op_valid <= 1'b0;
		ops <= ~o;
		base_fn <= ~fn;
		for (int i = 0; i < 4 && !ok; i++) begin
			@(negedge ref_clk);
			if (result_valid === 1'b1) begin
				ok = 1'b1;
				got = {carry_out, result};
			end
		end
	endtask : issue

endmodule : extended_alu_op_decode_model
`default_nettype wire

//--- verif/tb.sv
// Self-checking testbench of the extended ALU.
`timescale 1ns/1ps
`default_nettype none

module tb;
	import extended_alu_op_pkg::*;

	logic ref_clk = 1'b0;
	logic nrst = 1'b0;
	logic [1:0] avs_address = 2'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic op_valid, extended_alu_op, base_arith, result_valid, carry_out;
	logic [7:0] base_fn;
	logic [31:0] result;
	operands_s ops;
	int miscompares = 0;
	int total_checks = 0;
	// Product and sum subterm codes, in the same row order.
	logic [7:0] pc [16] = '{8'h00, 8'haa, 8'h88, 8'h22, 8'ha0, 8'h0a,
		8'h80, 8'h2a, 8'ha8, 8'h02, 8'h08, 8'ha2, 8'h8a, 8'h20, 8'h28, 8'h82};
	logic [7:0] sc [16] = '{8'h00, 8'hff, 8'hcc, 8'h33, 8'hf0, 8'h0f,
		8'hc0, 8'h3f, 8'hfc, 8'h03, 8'h0c, 8'hf3, 8'hcf, 8'h30, 8'h3c, 8'hc3};

	extended_alu_op_top extended_alu_op_top_i (.ref_clk(ref_clk), .nrst(nrst),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(4'hf), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .op_valid(op_valid),
		.extended_alu_op(extended_alu_op), .base_fn(base_fn),
		.base_arith(base_arith), .ops(ops), .result_valid(result_valid),
		.result(result), .carry_out(carry_out));
	extended_alu_op_decode_model extended_alu_op_decode_model_i (.ref_clk(ref_clk),
		.op_valid(op_valid), .extended_alu_op(extended_alu_op),
		.base_fn(base_fn), .base_arith(base_arith), .ops(ops),
		.result_valid(result_valid), .result(result),
		.carry_out(carry_out));

	// Free-running 50 MHz clock.
	always #10ns ref_clk = ~ref_clk;

	// ************************************************************
	// Shared tasks
	// ************************************************************
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : report_and_stop

	task automatic check(input logic [32:0] got, input logic [32:0] exp);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
		end
	endtask : check

	// One bus transfer; the request is held until waitrequest is seen low.
	task automatic bus(input logic wr, input logic [1:0] adr,
		input logic [31:0] wd, output logic [31:0] rd);
		logic done;
		done = 1'b0;
		rd = '0;
		@(posedge ref_clk);
		avs_address <= adr;
		avs_writedata <= wd;
		avs_write <= wr;
		avs_read <= !wr;
		for (int i = 0; i < 8 && !done; i++) begin
			@(negedge ref_clk);
			if (avs_waitrequest === 1'b0) begin
				done = 1'b1;
				rd = avs_readdata;
			end
		end
		@(posedge ref_clk);
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (!done) begin
			miscompares++;
			report_and_stop();
		end
	endtask : bus

	task automatic ctl(input logic [7:0] code, input logic ar,
		input logic [1:0] ad, input logic se, input logic ss);
		logic [31:0] rd;
		bus(1'b1, 2'h0, {ss, se, ad, ar, code, 19'h0}, rd);
	endtask : ctl

	task automatic op(input logic ext, input logic [7:0] fn, input logic ar,
		input logic [31:0] a, b, c, input logic cin, input logic [32:0] exp);
		logic [32:0] got;
		logic ok;
		extended_alu_op_decode_model_i.issue(ext, fn, ar, '{a: a, b: b, c: c, cin: cin},
			got, ok);
		if (!ok) begin
			miscompares++;
			report_and_stop();
		end
		check(got, exp);
	endtask : op

	// Subterm value of one table row; minus X minus one is the inverse of X.
	function automatic logic [31:0] sub(input int i, input logic [31:0] b, c);
		case (i)
			0: return 32'h0;
			1: return 32'hffff_ffff;
			2: return b;
			3: return ~b;
			4: return c;
			5: return ~c;
			6: return b & c;
			7: return ~(b & c);
			8: return b | c;
			9: return ~(b | c);
			10: return b & ~c;
			11: return ~(b & ~c);
			12: return b | ~c;
			13: return ~(b | ~c);
			14: return (b & ~c) | (~b & c);
			default: return (b & c) | (~b & ~c);
		endcase
	endfunction : sub

	// ************************************************************
	// Scenarios
	// ************************************************************
	task automatic t_regs();
		logic [31:0] rd;
		bus(1'b0, 2'h0, 32'h0, rd);
		check({1'b0, rd}, 33'h0);
		bus(1'b1, 2'h0, 32'hffff_ffff, rd);
		bus(1'b0, 2'h0, 32'h0, rd);
		check({1'b0, rd}, 33'h0_fff8_0000);
		bus(1'b1, 2'h3, 32'h1234_5678, rd);
		bus(1'b0, 2'h3, 32'h0, rd);
		check({1'b0, rd}, 33'h0);
		bus(1'b1, 2'h1, 32'hffff_ffff, rd);
		bus(1'b0, 2'h1, 32'h0, rd);
		check({1'b0, rd}, 33'h0);
		$display("registers test done");
	endtask : t_regs

	// Bit k of these operands selects minterm k mod 8, so the code repeats.
	task automatic t_bool();
		for (int i = 0; i < 256; i++) begin
			ctl(8'(i), 1'b0, 2'h0, 1'b0, 1'b0);
			op(1'b1, 8'h00, 1'b0, 32'haaaa_aaaa, 32'hcccc_cccc, 32'hf0f0_f0f0,
				1'b1, {1'b0, {4{8'(i)}}});
		end
		ctl(8'hff, 1'b0, 2'(add_one), 1'b0, 1'b0);
		op(1'b1, 8'h00, 1'b0, 0, 0, 0, 1'b0, 33'h1_0000_0000);
		ctl(8'hff, 1'b0, 2'(add_cin), 1'b0, 1'b0);
		op(1'b1, 8'h00, 1'b0, 0, 0, 0, 1'b1, 33'h1_0000_0000);
		op(1'b1, 8'h00, 1'b0, 0, 0, 0, 1'b0, 33'h0_ffff_ffff);
		$display("boolean test done");
	endtask : t_bool

	task automatic t_arith();
		logic [31:0] a, b, c;
		logic [32:0] e;
		a = 32'h9abc_def0;
		b = 32'h1357_9bdf;
		c = 32'h00ff_f00f;
		for (int i = 0; i < 16; i++) begin
			for (int j = 0; j < 16; j++) begin
				ctl(pc[i] ^ sc[j], 1'b1, 2'h0, 1'b0, 1'b0);
				e = {1'b0, a & sub(i, b, c)} + {1'b0, sub(j, b, c)};
				op(1'b1, 8'h00, 1'b0, a, b, c, 1'b0, e);
			end
		end
		ctl(8'haa ^ 8'hcc, 1'b1, 2'(add_cin), 1'b0, 1'b0);
		op(1'b1, 8'h00, 1'b0, 32'hffff_ffff, 32'h1, 0, 1'b1, 33'h1_0000_0001);
		$display("arithmetic test done");
	endtask : t_arith

	task automatic t_sign();
		ctl(8'hcc, 1'b1, 2'h0, 1'b1, 1'b0);
		op(1'b1, 8'h00, 1'b0, 0, -5, -5, 1'b0, 33'h5);
		op(1'b1, 8'h00, 1'b0, 0, 7, 7, 1'b0, 33'h7);
		ctl(8'hcc, 1'b1, 2'h0, 1'b1, 1'b1);
		op(1'b1, 8'h00, 1'b0, 0, -5, 0, 1'b0, 33'h5);
		ctl(8'hcc, 1'b1, 2'h0, 1'b0, 1'b0);
		op(1'b1, 8'h00, 1'b0, 0, -5, -5, 1'b0, 33'h0_ffff_fffb);
		$display("sign test done");
	endtask : t_sign

	// Base ops ignore the control code and its add selection.
	task automatic t_base();
		ctl(8'h00, 1'b0, 2'(add_one), 1'b0, 1'b0);
		op(1'b0, 8'hff, 1'b0, 0, 0, 0, 1'b1, 33'h0_ffff_ffff);
		op(1'b0, 8'h66, 1'b1, 5, 3, 0, 1'b1, 33'h8);
		$display("base test done");
	endtask : t_base

	// Main sequence.
	initial begin
		repeat (16) @(posedge ref_clk);
		nrst <= 1'b1;
		t_regs();
		t_bool();
		t_arith();
		t_sign();
		t_base();
		report_and_stop();
	end

endmodule : tb
`default_nettype wire
